// ==== src/lbm_pkg.sv ====
// Package: register map, field positions, reset values and timing for link bus management regs
package lbm_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0]  OFS_INIT_LOW_CHAN  = 8'hb8;
   localparam logic [7:0]  OFS_FAIRNESS       = 8'hdc;
   localparam logic [7:0]  OFS_LINK_SET       = 8'he0;
   localparam logic [7:0]  OFS_LINK_CLR       = 8'he4;
   localparam logic [7:0]  OFS_CYCLE_STATUS   = 8'he8;

   // Reset values
   localparam logic [31:0] RST_INIT_LOW_CHAN  = 32'hffffffff;
   localparam logic [7:0]  RST_FAIRNESS       = 8'h00;
   localparam logic [31:0] RST_LINK_CTRL      = 32'h00000000;

   // Link control field positions
   localparam int          BIT_EXT_ROLLOVER   = 22;
   localparam int          BIT_ROOT_CYCLE     = 21;
   localparam int          BIT_TIMER_ENABLE   = 20;
   localparam int          BIT_ACCEPT_PHY     = 10;
   localparam int          BIT_ACCEPT_SELF_ID = 9;
   localparam int          BIT_FORCE_TAG_ONE  = 6;
   localparam logic [31:0] LINK_RSC_MASK      = 32'h00700600;
   localparam logic [31:0] LINK_RW_MASK       = 32'h00700640;
   localparam int          FAIR_W             = 8;

   // Cycle timer: 3072 ticks of 24.576 MHz = 125 us; counted at 200 MHz
   localparam int          CYCLE_TICKS        = 3072;
   localparam int          TICK_CLK_KHZ       = 24576;
   localparam int          SYS_CLK_KHZ        = 200000;
   localparam int          CYCLE_SYS_CLKS     = (CYCLE_TICKS * SYS_CLK_KHZ) / TICK_CLK_KHZ;
   localparam int          CNT_W              = 15;
   localparam logic [CNT_W-1:0] CYCLE_LAST    = CNT_W'(CYCLE_SYS_CLKS - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO      = '0;
   localparam logic [CNT_W-1:0] CNT_ONE       = CNT_W'(1);
endpackage

// ==== src/lbm_cycle_timer.sv ====
// Cycle timer: rolls over internally or on external input
`timescale 1ns/1ps
module lbm_cycle_timer (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Control
   input  wire logic                     enable,
   input  wire logic                     ext_select,
   input  wire logic                     ext_tick,
   // Status
   output logic                          rollover,
   output logic [lbm_pkg::CNT_W-1:0]     count
);
   logic [lbm_pkg::CNT_W-1:0] cnt_ff;
   logic [lbm_pkg::CNT_W-1:0] nxt_cnt;
   logic                      roll_ff;
   wire                       int_roll;
   wire                       do_roll;

   assign int_roll = (cnt_ff == lbm_pkg::CYCLE_LAST);
   assign do_roll  = enable & (ext_select ? ext_tick : int_roll);
   assign nxt_cnt  = !enable ? cnt_ff :
                     do_roll ? lbm_pkg::CNT_ZERO :
                     (int_roll ? cnt_ff : cnt_ff + lbm_pkg::CNT_ONE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff  <= lbm_pkg::CNT_ZERO;
         roll_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         roll_ff <= do_roll;
      end
   end

   assign rollover = roll_ff;
   assign count    = cnt_ff;
endmodule

// ==== src/lbm_regs.sv ====
// Link bus management control registers: channels, fairness, link control
`timescale 1ns/1ps
module lbm_regs (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   // Reset sources
   input  wire logic        SOFT_RESET,
   input  wire logic        GLOBAL_RESET,
   input  wire logic        HOST_BUS_RESET,
   input  wire logic        BUS_RESET_1394,
   // Register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   // Cycle timer and events
   input  wire logic        CYCLE_IN,
   input  wire logic        OVERLONG_CYCLE_EVENT,
   output logic             CYCLE_ROLLOVER,
   // Link control outputs
   output logic             EXTERNAL_ROLLOVER_SELECT,
   output logic             ROOT_CYCLE_GENERATOR,
   output logic             CYCLE_TIMER_ENABLE,
   output logic             ACCEPT_PHY_PACKETS,
   output logic             ACCEPT_SELF_IDENTIFICATION,
   output logic             FORCE_TAG_ONE_FILTER,
   // Fairness and bus management CSR
   output logic [7:0]       PRIORITY_REQUEST_LIMIT,
   output logic [31:0]      CHANNELS_AVAILABLE_LO,
   output logic             CHANNELS_LOAD
);
   ////////////////////////////////////////////////////////////////////////////
   // Decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire        wr_init  = WR & hit(ADDR, lbm_pkg::OFS_INIT_LOW_CHAN);
   wire        wr_fair  = WR & hit(ADDR, lbm_pkg::OFS_FAIRNESS);
   wire        wr_set   = WR & hit(ADDR, lbm_pkg::OFS_LINK_SET);
   wire        wr_clr   = WR & hit(ADDR, lbm_pkg::OFS_LINK_CLR);
   wire        sw_reset = SOFT_RESET;
   wire        csr_load = GLOBAL_RESET | HOST_BUS_RESET | BUS_RESET_1394;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] init_lo_ff;
   logic [31:0] nxt_init_lo;
   logic [7:0]  fair_ff;
   logic [7:0]  nxt_fair;
   logic [31:0] link_ff;
   logic [31:0] nxt_link;
   logic [31:0] chan_ff;
   logic [31:0] nxt_chan;
   logic        load_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        overlong_ff;
   logic        roll_w;
   logic [lbm_pkg::CNT_W-1:0] cycle_count;

   assign nxt_init_lo = sw_reset ? lbm_pkg::RST_INIT_LOW_CHAN :
                        wr_init  ? WDATA : init_lo_ff;

   assign nxt_fair = sw_reset ? lbm_pkg::RST_FAIRNESS :
                     wr_fair  ? WDATA[lbm_pkg::FAIR_W-1:0] : fair_ff;

   assign nxt_chan = csr_load ? init_lo_ff : chan_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Link control set/clear
   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic [31:0] link_after;
   logic        root_block;

   assign set_bits   = wr_set ? (WDATA & lbm_pkg::LINK_RW_MASK) : 32'h00000000;
   assign clr_bits   = wr_clr ? (WDATA & lbm_pkg::LINK_RSC_MASK) : 32'h00000000;
   assign root_block = OVERLONG_CYCLE_EVENT | overlong_ff;

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_link
         if (gi == lbm_pkg::BIT_ROOT_CYCLE) begin : g_root
            assign link_after[gi] = root_block ? 1'b0 :
                                    ((link_ff[gi] | set_bits[gi]) & ~clr_bits[gi]);
         end else if (gi == lbm_pkg::BIT_FORCE_TAG_ONE) begin : g_lock
            assign link_after[gi] = GLOBAL_RESET ? 1'b0 : (link_ff[gi] | set_bits[gi]);
         end else begin : g_plain
            assign link_after[gi] = (link_ff[gi] | set_bits[gi]) & ~clr_bits[gi];
         end
      end
   endgenerate

   assign nxt_link = sw_reset ? lbm_pkg::RST_LINK_CTRL : link_after;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, data one cycle after strobe
   wire [31:0] link_rd = link_ff & lbm_pkg::LINK_RW_MASK;
   wire [31:0] status_rd = {16'h0000, overlong_ff, cycle_count};

   assign nxt_rdata = !RD ? 32'h00000000 :
                      hit(ADDR, lbm_pkg::OFS_INIT_LOW_CHAN) ? init_lo_ff :
                      hit(ADDR, lbm_pkg::OFS_FAIRNESS)      ? {24'h000000, fair_ff} :
                      hit(ADDR, lbm_pkg::OFS_LINK_SET)      ? link_rd :
                      hit(ADDR, lbm_pkg::OFS_LINK_CLR)      ? link_rd :
                      hit(ADDR, lbm_pkg::OFS_CYCLE_STATUS)  ? status_rd :
                      32'h00000000;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         init_lo_ff  <= lbm_pkg::RST_INIT_LOW_CHAN;
         fair_ff     <= lbm_pkg::RST_FAIRNESS;
         link_ff     <= lbm_pkg::RST_LINK_CTRL;
         chan_ff     <= lbm_pkg::RST_INIT_LOW_CHAN;
         load_ff     <= 1'b0;
         rdata_ff    <= 32'h00000000;
         overlong_ff <= 1'b0;
      end else begin
         init_lo_ff  <= nxt_init_lo;
         fair_ff     <= nxt_fair;
         link_ff     <= nxt_link;
         chan_ff     <= nxt_chan;
         load_ff     <= csr_load;
         rdata_ff    <= nxt_rdata;
         overlong_ff <= OVERLONG_CYCLE_EVENT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle timer
   // rollover source select
   lbm_cycle_timer u_timer (
      .clk        (SYS_CLK),
      .rst_b      (RST_B),
      .enable     (link_ff[lbm_pkg::BIT_TIMER_ENABLE]),
      .ext_select (link_ff[lbm_pkg::BIT_EXT_ROLLOVER]),
      .ext_tick   (CYCLE_IN),
      .rollover   (roll_w),
      .count      (cycle_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign RDATA                      = rdata_ff;
   assign CYCLE_ROLLOVER             = roll_w;
   assign EXTERNAL_ROLLOVER_SELECT   = link_ff[lbm_pkg::BIT_EXT_ROLLOVER];
   assign ROOT_CYCLE_GENERATOR       = link_ff[lbm_pkg::BIT_ROOT_CYCLE];
   assign CYCLE_TIMER_ENABLE         = link_ff[lbm_pkg::BIT_TIMER_ENABLE];
   assign ACCEPT_PHY_PACKETS         = link_ff[lbm_pkg::BIT_ACCEPT_PHY];
   assign ACCEPT_SELF_IDENTIFICATION = link_ff[lbm_pkg::BIT_ACCEPT_SELF_ID];
   assign FORCE_TAG_ONE_FILTER       = link_ff[lbm_pkg::BIT_FORCE_TAG_ONE];
   assign PRIORITY_REQUEST_LIMIT     = fair_ff;
   assign CHANNELS_AVAILABLE_LO      = chan_ff;
   assign CHANNELS_LOAD              = load_ff;
endmodule

// ==== testbench/lbm_regs_properties.sv ====
// Port checker for the link bus management registers
`timescale 1ns/1ps
module lbm_regs_properties (
   input wire logic        SYS_CLK, RST_B, SOFT_RESET, GLOBAL_RESET, BUS_RESET_1394,
   input wire logic [7:0]  ADDR, PRIORITY_REQUEST_LIMIT,
   input wire logic [31:0] WDATA, RDATA,
   input wire logic        WR, RD, OVERLONG_CYCLE_EVENT, EXTERNAL_ROLLOVER_SELECT,
   input wire logic        ROOT_CYCLE_GENERATOR, CYCLE_TIMER_ENABLE, ACCEPT_PHY_PACKETS,
   input wire logic        ACCEPT_SELF_IDENTIFICATION, FORCE_TAG_ONE_FILTER, CHANNELS_LOAD
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   wire logic [31:0] link_view = {9'h0, EXTERNAL_ROLLOVER_SELECT, ROOT_CYCLE_GENERATOR,
      CYCLE_TIMER_ENABLE, 9'h0, ACCEPT_PHY_PACKETS, ACCEPT_SELF_IDENTIFICATION, 2'h0,
      FORCE_TAG_ONE_FILTER, 6'h0};
   sequence s_read(a); RD && ADDR == a; endsequence
   sequence s_write(a, b); WR && ADDR == a && WDATA[b]; endsequence
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data not idle");
   chk_fair_read: assert property (s_read(8'hdc) |=> RDATA == {24'h0, $past(PRIORITY_REQUEST_LIMIT)})
      else $error("fairness read wrong");
   chk_link_read: assert property (s_read(8'he0) or s_read(8'he4) |=> RDATA == $past(link_view))
      else $error("link control read wrong");
   chk_set_timer: assert property (s_write(8'he0, 20) |=> CYCLE_TIMER_ENABLE)
      else $error("set port ignored");
   chk_clear_self_id: assert property (s_write(8'he4, 9) |=> !ACCEPT_SELF_IDENTIFICATION)
      else $error("clear port ignored");
   chk_clear_root: assert property (s_write(8'he4, 21) |=> !ROOT_CYCLE_GENERATOR)
      else $error("root bit not cleared");
   chk_lock_sticky: assert property (FORCE_TAG_ONE_FILTER && !GLOBAL_RESET && !SOFT_RESET
      |=> FORCE_TAG_ONE_FILTER)
      else $error("lock bit dropped");
   chk_lock_clear: assert property (GLOBAL_RESET |=> !FORCE_TAG_ONE_FILTER)
      else $error("lock bit kept");
   chk_root_block: assert property (OVERLONG_CYCLE_EVENT |=> !ROOT_CYCLE_GENERATOR)
      else $error("root bit kept");
   chk_chan_load: assert property (GLOBAL_RESET || BUS_RESET_1394 |-> ##[1:2] CHANNELS_LOAD)
      else $error("channels not loaded");
endmodule
bind lbm_regs lbm_regs_properties u_lbm_regs_properties (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
   .SOFT_RESET(SOFT_RESET), .GLOBAL_RESET(GLOBAL_RESET), .BUS_RESET_1394(BUS_RESET_1394),
   .ADDR(ADDR), .PRIORITY_REQUEST_LIMIT(PRIORITY_REQUEST_LIMIT), .WDATA(WDATA), .RDATA(RDATA),
   .WR(WR), .RD(RD), .OVERLONG_CYCLE_EVENT(OVERLONG_CYCLE_EVENT),
   .EXTERNAL_ROLLOVER_SELECT(EXTERNAL_ROLLOVER_SELECT), .ROOT_CYCLE_GENERATOR(ROOT_CYCLE_GENERATOR),
   .CYCLE_TIMER_ENABLE(CYCLE_TIMER_ENABLE), .ACCEPT_PHY_PACKETS(ACCEPT_PHY_PACKETS),
   .ACCEPT_SELF_IDENTIFICATION(ACCEPT_SELF_IDENTIFICATION),
   .FORCE_TAG_ONE_FILTER(FORCE_TAG_ONE_FILTER), .CHANNELS_LOAD(CHANNELS_LOAD));

// ==== testbench/lbm_phy_model.sv ====
// Far side: cycle input source, overlong events, rollover count
`timescale 1ns/1ps
module lbm_phy_model (
   input  wire logic clk, rst_b, tick_req, ovl_req, rollover,
   output logic      cycle_in, overlong,
   output int        rollovers
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cycle_in <= 1'b0;
         overlong <= 1'b0;
         rollovers <= 0;
      end else begin
         cycle_in <= tick_req;
         overlong <= ovl_req;
         rollovers <= rollovers + int'(rollover);
      end
   end
endmodule

// ==== testbench/lbm_regs_tb_top.sv ====
// Self-checking bench for the link bus management registers
`timescale 1ns/1ps
module lbm_regs_tb_top;
   logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, tick_req = 1'b0, ovl_req = 1'b0;
   logic [3:0]  rst_src = 4'h0;
   logic [7:0]  addr = 8'h00, lim;
   logic [31:0] wdata = 32'h0, rdata, chan;
   logic        cyc_in, ovl, roll, root;
   int          rollovers, n, failures = 0, check_count = 0;
   lbm_regs u_lbm_regs (.SYS_CLK(clk), .RST_B(rst_b), .SOFT_RESET(rst_src[0]),
      .GLOBAL_RESET(rst_src[1]), .HOST_BUS_RESET(rst_src[2]), .BUS_RESET_1394(rst_src[3]),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CYCLE_IN(cyc_in),
      .OVERLONG_CYCLE_EVENT(ovl), .CYCLE_ROLLOVER(roll), .EXTERNAL_ROLLOVER_SELECT(),
      .ROOT_CYCLE_GENERATOR(root), .CYCLE_TIMER_ENABLE(), .ACCEPT_PHY_PACKETS(),
      .ACCEPT_SELF_IDENTIFICATION(), .FORCE_TAG_ONE_FILTER(), .PRIORITY_REQUEST_LIMIT(lim),
      .CHANNELS_AVAILABLE_LO(chan), .CHANNELS_LOAD());
   lbm_phy_model u_lbm_phy_model (.clk(clk), .rst_b(rst_b), .tick_req(tick_req),
      .ovl_req(ovl_req), .rollover(roll), .cycle_in(cyc_in), .overlong(ovl), .rollovers(rollovers));
   initial forever #2.5 clk = ~clk;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task automatic rd32(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) rd <= 1'b1;
      addr <= a;
      @(posedge clk) rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask
   task automatic pulse(input int i);
      @(posedge clk) rst_src[i] <= 1'b1;
      @(posedge clk) rst_src[i] <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_channels;
      rd32(8'hb8, 32'hffffffff);
      rd32(8'h40, 32'h0);
      rd32(8'he8, 32'h0);
      wr32(8'hb8, 32'ha5a50f0f);
      rd32(8'hb8, 32'ha5a50f0f);
      pulse(3);
      cmp(chan, 32'ha5a50f0f);
      rd32(8'hb8, 32'ha5a50f0f);
      wr32(8'hb8, 32'h0000ffff);
      pulse(2);
      cmp(chan, 32'h0000ffff);
   endtask
   task automatic t_fair_link;
      rd32(8'hdc, 32'h0);
      wr32(8'hdc, 32'hffffffff);
      rd32(8'hdc, 32'h000000ff);
      cmp(lim, 32'hff);
      wr32(8'he0, 32'hffffffff);
      rd32(8'he4, 32'h00700640);
      wr32(8'he4, 32'hffffffff);
      rd32(8'he0, 32'h00000040);
      pulse(1);
      rd32(8'he0, 32'h0);
   endtask
   task automatic t_overlong;
      wr32(8'he0, 32'h00200000);
      cmp(root, 1'b1);
      @(posedge clk) ovl_req <= 1'b1;
      repeat (3) @(posedge clk);
      wr32(8'he0, 32'h00200000);
      cmp(root, 1'b0);
      @(posedge clk) ovl_req <= 1'b0;
      repeat (3) @(posedge clk);
      wr32(8'he0, 32'h00200000);
      cmp(root, 1'b1);
      wr32(8'hb8, 32'h0);
      pulse(0);
      rd32(8'hb8, 32'hffffffff);
      rd32(8'hdc, 32'h0);
   endtask
   task automatic t_timer;
      wr32(8'he0, 32'h00500000);
      n = rollovers;
      @(posedge clk) tick_req <= 1'b1;
      @(posedge clk) tick_req <= 1'b0;
      repeat (4) @(posedge clk);
      cmp(rollovers, n + 1);
      wr32(8'he4, 32'h00400000);
      for (n = 0; n < 26000 && roll !== 1'b1; n++) @(posedge clk) #1;
      n = 0;
      do @(posedge clk) #1 n++; while (roll !== 1'b1 && n < 26000);
      cmp(n, 3072 * 200000 / 24576);
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_channels;
      t_fair_link;
      t_overlong;
      t_timer;
      wrap_up;
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      wrap_up;
   end
endmodule
